/* logic/serial_port_routing_config.sv */
// register bank and routing decode for the two audio serial ports
// assumes a single 40 MHz clock and an axi4-lite master keeping one transfer of each kind open
`timescale 1ns/100ps
module serial_port_routing_config
	import serial_port_routing_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// decoded routing
	output route_s route_q
);
	logic [7:0] bias_q;
	logic [7:0] port_q;
	logic [7:0] lane_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic aw_held_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic w_held_q;
	route_s route_d;

	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[IDX_LSB +: 8];
	endfunction : reg_index

	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		logic [7:0] idx;
		idx = reg_index(addr);
		is_mapped = (addr[IDX_LSB-1:0] == 2'h0) && ((idx == BIAS_PIN_CONTROL_IDX) ||
			(idx == SERIAL_PORT_CONTROL_IDX) || (idx == SERIAL_LANE_CONTROL_IDX));
	endfunction : is_mapped

	// code 3 is not masked on write, and the reserved lane code falls to split
	function automatic logic [3:0] lane_split(input logic [1:0] mode);
		case (mode)
			LANES_PRIMARY: lane_split = LANES_TWO_PRIMARY;
			LANES_SECONDARY: lane_split = LANES_TWO_SECONDARY;
			default: lane_split = LANES_ONE_EACH;
		endcase
	endfunction : lane_split

	// write channel capture, address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
		end
	end

	logic wr_go;
	assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

	// register writes; reserved bits masked to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bias_q <= BIAS_PIN_CONTROL_RST;
			port_q <= SERIAL_PORT_CONTROL_RST;
			lane_q <= SERIAL_LANE_CONTROL_RST;
		end else if (wr_go && is_mapped(awaddr_q) && wstrb_q[0]) begin
			case (reg_index(awaddr_q))
				BIAS_PIN_CONTROL_IDX: bias_q <= wdata_q[7:0] & BIAS_PIN_CONTROL_MASK;
				SERIAL_PORT_CONTROL_IDX: port_q <= wdata_q[7:0] & SERIAL_PORT_CONTROL_MASK;
				SERIAL_LANE_CONTROL_IDX: lane_q <= wdata_q[7:0] & SERIAL_LANE_CONTROL_MASK;
				default: bias_q <= bias_q;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (reg_index(s_axi_araddr))
				BIAS_PIN_CONTROL_IDX: s_axi_rdata <= {24'h000000, bias_q};
				SERIAL_PORT_CONTROL_IDX: s_axi_rdata <= {24'h000000, port_q};
				SERIAL_LANE_CONTROL_IDX: s_axi_rdata <= {24'h000000, lane_q};
				default: s_axi_rdata <= 32'h00000000;
			endcase
			if (!is_mapped(s_axi_araddr)) begin
				s_axi_rdata <= 32'h00000000;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// routing decode
	always_comb begin
		logic [3:0] outs;
		logic [3:0] ins;
		chain_mode_e chain;
		outs = lane_split(lane_q[OUT_LANE_LSB +: 2]);
		ins = lane_split(lane_q[IN_LANE_LSB +: 2]);
		chain = chain_mode_e'(port_q[CHAIN_MODE_LSB +: 2]);
		route_d = '0;
		route_d.bias_pin = bias_q[BIAS_SEL_LSB +: 2];
		route_d.primary_en = !port_q[PRIMARY_OFF_BIT] && (chain != CHAIN_SECONDARY);
		route_d.secondary_en = !port_q[SECONDARY_OFF_BIT] && (chain != CHAIN_PRIMARY);
		route_d.secondary_uses_primary_cfg = port_q[GANG_BIT];
		route_d.chain_primary = (chain == CHAIN_PRIMARY);
		route_d.chain_secondary = (chain == CHAIN_SECONDARY);
		route_d.chain_on_input = lane_q[CHAIN_DIR_BIT];
		case (port_q[CHAIN_SRC_LSB +: 3])
			SRC_GENERAL_ONE, SRC_INPUT_TWO_A, SRC_INPUT_ONE_A, SRC_DATA_IN: begin
				route_d.chain_src = port_q[CHAIN_SRC_LSB +: 3];
			end
			default: route_d.chain_src = SRC_DISABLED;
		endcase
		if (chain != CHAIN_OFF) begin
			// chaining leaves each enabled port with one output and one input
			outs = LANES_ONE_EACH;
			ins = LANES_ONE_EACH;
		end
		route_d.primary_out_lanes = outs[3:2];
		route_d.secondary_out_lanes = outs[1:0];
		route_d.primary_in_lanes = ins[3:2];
		route_d.secondary_in_lanes = ins[1:0];
		if (!route_d.primary_en) begin
			route_d.primary_out_lanes = 2'h0;
			route_d.primary_in_lanes = 2'h0;
		end
		if (!route_d.secondary_en) begin
			route_d.secondary_out_lanes = 2'h0;
			route_d.secondary_in_lanes = 2'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			route_q <= '0;
		end else begin
			route_q <= route_d;
		end
	end
endmodule : serial_port_routing_config

/* inc/serial_port_routing_pkg.sv */
// constants and types for the serial port routing configuration block
// assumes an axi4-lite master with 32-bit data and one aligned word per register
// Operation
// - bias select picks pin enabling mic bias
// - primary port off bit, resets 0
// - secondary port off bit, resets 1
// - gang makes secondary copy primary settings
// - chain enable selects daisy mode per port
// - chain source pick; codes 4,6,7 reserved
// - output lanes split between the two ports
// - input lanes split between the two ports
// - chain direction: output path or input path
// - reserved bits read zero, write zero
package serial_port_routing_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] BIAS_PIN_CONTROL_IDX = 8'h15;
	localparam logic [7:0] SERIAL_PORT_CONTROL_IDX = 8'h18;
	localparam logic [7:0] SERIAL_LANE_CONTROL_IDX = 8'h19;
	localparam logic [7:0] BIAS_PIN_CONTROL_RST = 8'h00;
	localparam logic [7:0] SERIAL_PORT_CONTROL_RST = 8'h40;
	localparam logic [7:0] SERIAL_LANE_CONTROL_RST = 8'h00;
	// writable bit masks; all other bits reserved
	localparam logic [7:0] BIAS_PIN_CONTROL_MASK = 8'hc0;
	localparam logic [7:0] SERIAL_PORT_CONTROL_MASK = 8'hff;
	localparam logic [7:0] SERIAL_LANE_CONTROL_MASK = 8'hf8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int ADDR_W = 12;
	localparam int IDX_LSB = 2;
	// field positions inside the three registers
	localparam int BIAS_SEL_LSB = 6;
	localparam int PRIMARY_OFF_BIT = 7;
	localparam int SECONDARY_OFF_BIT = 6;
	localparam int GANG_BIT = 5;
	localparam int CHAIN_MODE_LSB = 3;
	localparam int CHAIN_SRC_LSB = 0;
	localparam int OUT_LANE_LSB = 6;
	localparam int IN_LANE_LSB = 4;
	localparam int CHAIN_DIR_BIT = 3;
	// lane counts packed as {primary, secondary}
	localparam logic [3:0] LANES_TWO_PRIMARY = 4'h8;
	localparam logic [3:0] LANES_TWO_SECONDARY = 4'h2;
	localparam logic [3:0] LANES_ONE_EACH = 4'h5;

	typedef enum logic [1:0] {
		PIN_NONE = 2'b00,
		PIN_GENERAL_ONE = 2'b01,
		PIN_INPUT_TWO_A = 2'b10,
		PIN_INPUT_ONE_A = 2'b11
	} pin_sel_e;

	typedef enum logic [1:0] {
		CHAIN_OFF = 2'b00,
		CHAIN_PRIMARY = 2'b01,
		CHAIN_SECONDARY = 2'b10,
		CHAIN_RESERVED = 2'b11
	} chain_mode_e;

	typedef enum logic [2:0] {
		SRC_DISABLED = 3'b000,
		SRC_GENERAL_ONE = 3'b001,
		SRC_INPUT_TWO_A = 3'b010,
		SRC_INPUT_ONE_A = 3'b011,
		SRC_DATA_IN = 3'b101
	} chain_src_e;

	typedef enum logic [1:0] {
		LANES_SPLIT = 2'b00,
		LANES_PRIMARY = 2'b01,
		LANES_SECONDARY = 2'b10
	} lane_mode_e;

	// decoded routing outputs
	typedef struct packed {
		logic primary_en;
		logic secondary_en;
		logic secondary_uses_primary_cfg;
		logic [1:0] primary_out_lanes;
		logic [1:0] secondary_out_lanes;
		logic [1:0] primary_in_lanes;
		logic [1:0] secondary_in_lanes;
		logic chain_primary;
		logic chain_secondary;
		logic chain_on_input;
		logic [2:0] chain_src;
		logic [1:0] bias_pin;
	} route_s;
endpackage : serial_port_routing_pkg

/* test/routing_props.sv */
// assertions on read data and decoded routing
// assumes bind onto the bank top module
`timescale 1ns/100ps
module routing_props
	import serial_port_routing_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// watched outputs
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire route_s route_q
);
	route_s q;
	logic both;
	logic [3:0] pl, sl;
	assign q = route_q;
	assign pl = {q.primary_out_lanes, q.primary_in_lanes};
	assign sl = {q.secondary_out_lanes, q.secondary_in_lanes};
	assign both = q.primary_en && q.secondary_en && !q.chain_primary && !q.chain_secondary;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	rdata_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata high");
	pri_chain_a: assert property (q.chain_primary |-> !q.secondary_en && !q.chain_secondary) else $error("chain");
	sec_chain_a: assert property (q.chain_secondary |-> !q.primary_en) else $error("chain");
	pri_one_a: assert property (q.chain_primary && q.primary_en |-> pl == 4'h5) else $error("lanes");
	sec_one_a: assert property (q.chain_secondary && q.secondary_en |-> sl == 4'h5) else $error("lanes");
	out_split_a:
		assert property (both |-> q.primary_out_lanes + q.secondary_out_lanes == 3'h2) else $error("outs");
	in_split_a:
		assert property (both |-> q.primary_in_lanes + q.secondary_in_lanes == 3'h2) else $error("ins");
	pri_off_a: assert property (!q.primary_en |-> pl == 4'h0) else $error("off");
	sec_off_a: assert property (!q.secondary_en |-> sl == 4'h0) else $error("off");
endmodule : routing_props
bind serial_port_routing_config routing_props u_props (.aclk, .aresetn, .s_axi_rdata, .s_axi_rvalid, .route_q);

/* test/test_serial_port_routing_config.sv */
// random and corner tests of the routing register bank
// assumes an axi4-lite slave answering in its own time
`timescale 1ns/100ps
module test_serial_port_routing_config
	import serial_port_routing_pkg::*;
;
	logic aclk = 0, aresetn = 0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	route_s route_q;
	logic [7:0] v;
	logic [7:0] regs [3];
	logic [7:0] idx [3] = '{BIAS_PIN_CONTROL_IDX, SERIAL_PORT_CONTROL_IDX, SERIAL_LANE_CONTROL_IDX};
	logic [7:0] msk [3] = '{BIAS_PIN_CONTROL_MASK, SERIAL_PORT_CONTROL_MASK, SERIAL_LANE_CONTROL_MASK};
	int failures = 0, checked = 0, j;
	always #12.5 aclk = ~aclk;
	serial_port_routing_config u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .route_q);
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		checked++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic bus(logic w, logic [7:0] i, logic [7:0] b, logic [3:0] s);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_araddr} <= {2{2'h0, i, 2'h0}};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
		s_axi_wdata <= $urandom << 8 | b;
		s_axi_wstrb <= s;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!(s_axi_bvalid || s_axi_rvalid));
		{d, r} = w ? {32'h0, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
		{s_axi_bready, s_axi_rready} <= 2'h0;
	endtask : bus
	function automatic route_s model();
		route_s m;
		logic [1:0] c, o, n;
		{c, o, n} = {regs[1][4:3], regs[2][7:4]};
		m = '0;
		m.primary_en = !regs[1][7] && c != 2;
		m.secondary_en = !regs[1][6] && c != 1;
		m.secondary_uses_primary_cfg = regs[1][5];
		{m.chain_primary, m.chain_secondary, m.chain_on_input} = {c == 1, c == 2, regs[2][3]};
		m.chain_src = regs[1][2:0] inside {4, 6, 7} ? 3'h0 : regs[1][2:0];
		m.bias_pin = regs[0][7:6];
		m.primary_out_lanes = c == 1 ? 2'h1 : 2'h1 + (o == 1) - (o == 2);
		m.primary_in_lanes = c == 1 ? 2'h1 : 2'h1 + (n == 1) - (n == 2);
		m.secondary_out_lanes = c == 2 ? 2'h1 : 2'h1 - (o == 1) + (o == 2);
		m.secondary_in_lanes = c == 2 ? 2'h1 : 2'h1 - (n == 1) + (n == 2);
		if (!m.primary_en) {m.primary_out_lanes, m.primary_in_lanes} = '0;
		if (!m.secondary_en) {m.secondary_out_lanes, m.secondary_in_lanes} = '0;
		return m;
	endfunction : model
	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial begin
		void'($urandom(32'h255b4581));
		regs = '{8'h00, 8'h40, 8'h00};
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		chk("reset route", model(), route_q);
		for (int k = 0; k < 63; k++) begin
			j = k % 3;
			bus(0, idx[j], 8'h0, 4'h0);
			chk("rdata", {24'h0, regs[j]}, d);
			chk("rresp", RESP_OKAY, r);
			v = $urandom & msk[j];
			if (j == 0) v[7:6] = 2'(k / 3);
			if (j == 1) v[2:0] = 3'(k / 3);
			if (j == 1 && v[4:3] == 3) v[4] = 0;
			if (j == 2 && v[7:6] == 3) v[7] = 0;
			if (j == 2 && v[5:4] == 3) v[5] = 0;
			bus(1, idx[j], v, 4'h1);
			regs[j] = v;
			chk("bresp", RESP_OKAY, r);
			repeat (2) @(posedge aclk);
			chk("route", model(), route_q);
		end
		bus(1, idx[0], 8'hff, 4'h1);
		bus(1, idx[1], 8'h00, 4'h0);
		bus(0, idx[0], 8'h0, 4'h0);
		chk("reserved", 32'hc0, d);
		bus(0, idx[1], 8'h0, 4'h0);
		chk("strobe", {24'h0, regs[1]}, d);
		bus(0, 8'h16, 8'h0, 4'h0);
		chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		finish_test();
	end
	initial begin
		#100000;
		failures++;
		finish_test();
	end
endmodule : test_serial_port_routing_config
